// file: rtl/slot_hot_plug.sv
// Downstream slot hot-plug controller with Avalon-MM register slave
// Function
// - Controller active only while hot-plug capable set
// - Capable rise or address write configures expander
// - Initial expander access sets no changed bits
// - Presence from expander pin or in-band link
// - Each signal has its own polarity invert
// - Interlock command pulses output 100 to 150 ms
// - Toggle mode inverts interlock on each command
// - Substitution reports latch input as interlock state
// - Substitution forces latch state to read closed
// - Otherwise interlock state reads interlock output level
// - Open latch cuts power when auto-off enabled, latch present and no substitution
// - Power fault level followed live, never latched
// - Eeprom load sets no command completed; init after
// - Hot reset sends link to hot reset, retrain
// - Retraining after hot reset sets no presence change
// - Slot reset only on general purpose pin
// - Interrupt only while hot-plug irq enable set
// - Enabled status events request the interrupt
// - Interrupt as MSI or INTx per enables
// - D3hot with irq disabled gives wakeup only
// - D3hot with irq enabled gives both; masked neither
// - Command completed never causes a wakeup
`timescale 1ns/1ps
module slot_hot_plug #(
  parameter int unsigned INTERLOCK_CYCLES = hot_plug_pkg::INTERLOCK_PULSE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire hot_plug_pkg::sensor_in_t slot_sensors_i,
  output hot_plug_pkg::expander_out_t expander_o,
  output logic exp_req_o,
  output logic exp_init_o,
  output logic [6:0] exp_addr_o,
  input wire logic exp_ack_i,
  input wire logic eeprom_done_i,
  input wire logic hot_reset_i,
  input wire logic link_clk_i,
  input wire logic link_up_i,
  output logic link_hot_reset_o,
  output logic msi_req_o,
  output logic intx_o,
  output logic pme_req_o,
  output logic slot_reset_gpio_n_o
);

  // Synchroniser: [4:0] sensors, [5] ack, [6] link clock, [7] link up
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic link_clk_prev_q;
  logic link_present_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      link_clk_prev_q <= 1'b0;
      link_present_q <= 1'b0;
    end else begin
      sync1_q <= {link_up_i, link_clk_i, exp_ack_i, slot_sensors_i};
      sync2_q <= sync1_q;
      link_clk_prev_q <= sync2_q[6];
      if (sync2_q[6] && !link_clk_prev_q) begin
        link_present_q <= sync2_q[7];
      end
    end
  end

  wire ack_w = sync2_q[5];

  // Register state
  logic [1:0] cap_q;
  hot_plug_pkg::slot_control_t ctl_q;
  hot_plug_pkg::hot_plug_config_t cfg_q;
  hot_plug_pkg::power_state_t pwr_q;
  logic [6:0] addr_q;
  logic [4:0] evt_q;
  logic ack_q;
  logic [31:0] rdata_q;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = (old & ~lane_mask(be)) | (wd & lane_mask(be));
  endfunction

  // Bus decode; one wait state, then the access completes
  wire access_w = avs_read_i || avs_write_i;
  wire wr_w = avs_write_i && ack_q;
  wire [31:0] wmask_w = lane_mask(avs_byteenable_i);
  wire sel_cap_w = (avs_address_i == hot_plug_pkg::OFS_SLOT_CAPABILITIES);
  wire sel_ctl_w = (avs_address_i == hot_plug_pkg::OFS_SLOT_CONTROL);
  wire sel_sts_w = (avs_address_i == hot_plug_pkg::OFS_SLOT_STATUS);
  wire sel_cfg_w = (avs_address_i == hot_plug_pkg::OFS_HOT_PLUG_CONFIG);
  wire sel_adr_w = (avs_address_i == hot_plug_pkg::OFS_EXPANDER_ADDRESS);
  wire sel_pwr_w = (avs_address_i == hot_plug_pkg::OFS_POWER_STATE);
  wire hpc_w = cap_q[hot_plug_pkg::CAP_HOT_PLUG_CAPABLE_BIT];
  wire latch_present_w = cap_q[hot_plug_pkg::CAP_LATCH_PRESENT_BIT];
  wire wr_ctl_w = wr_w && sel_ctl_w;
  wire wr_adr_w = wr_w && sel_adr_w && avs_byteenable_i[0];
  wire interlock_fire_w = wr_ctl_w && hpc_w &&
                          avs_writedata_i[hot_plug_pkg::CTL_INTERLOCK_WRITE_BIT] &&
                          wmask_w[hot_plug_pkg::CTL_INTERLOCK_WRITE_BIT];

  // Polarity-corrected sensors, one invert bit per sensor in [4:0]
  hot_plug_pkg::sensor_in_t sens_w;
  assign sens_w = hot_plug_pkg::sensor_in_t'(sync2_q[4:0] ^ cfg_q.invert[4:0]);

  // Presence source and hot reset retrain window
  logic retrain_q;
  logic link_present_prev_q;
  wire presence_w = cfg_q.presence_detect_select ? link_present_q
                                                 : sens_w.presence_in;
  wire pd_frozen_w = retrain_q && cfg_q.presence_detect_select;

  // Expander access sequencing
  hot_plug_pkg::exp_state_t exp_state_q;
  hot_plug_pkg::exp_state_t exp_state_d;
  logic init_pend_q;
  logic upd_pend_q;
  logic kind_init_q;
  logic ready_q;
  logic hpc_prev_q;

  wire hpc_rise_w = hpc_w && !hpc_prev_q;
  // Init waits for eeprom load; command writes during load are not commands
  wire can_launch_w = hpc_w && eeprom_done_i;
  wire launch_w = (exp_state_q == hot_plug_pkg::EXP_IDLE) && can_launch_w &&
                  (init_pend_q || upd_pend_q);
  wire launch_init_w = launch_w && init_pend_q;
  wire done_w = (exp_state_q == hot_plug_pkg::EXP_REQ) && ack_w;
  wire init_set_w = hpc_rise_w || (wr_adr_w && hpc_w);
  wire upd_set_w = wr_ctl_w && can_launch_w && ready_q;

  always_comb begin
    exp_state_d = exp_state_q;
    unique case (exp_state_q)
      hot_plug_pkg::EXP_IDLE: begin
        if (launch_w) begin
          exp_state_d = hot_plug_pkg::EXP_REQ;
        end
      end
      hot_plug_pkg::EXP_REQ: begin
        if (ack_w) begin
          exp_state_d = hot_plug_pkg::EXP_DROP;
        end
      end
      hot_plug_pkg::EXP_DROP: begin
        if (!ack_w) begin
          exp_state_d = hot_plug_pkg::EXP_IDLE;
        end
      end
      default: begin
        exp_state_d = hot_plug_pkg::EXP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      exp_state_q <= hot_plug_pkg::EXP_IDLE;
      init_pend_q <= 1'b0;
      upd_pend_q <= 1'b0;
      kind_init_q <= 1'b0;
      ready_q <= 1'b0;
      hpc_prev_q <= 1'b0;
    end else begin
      exp_state_q <= exp_state_d;
      hpc_prev_q <= hpc_w;
      // New requests win over the launch that clears them
      init_pend_q <= hpc_w && ((init_pend_q && !launch_init_w) || init_set_w);
      upd_pend_q <= hpc_w && ((upd_pend_q && !(launch_w && !init_pend_q)) || upd_set_w);
      if (launch_w) begin
        kind_init_q <= init_pend_q;
      end
      if (!hpc_w || launch_init_w) begin
        ready_q <= 1'b0;
      end else if (done_w && kind_init_q) begin
        ready_q <= 1'b1;
      end
    end
  end

  // Change detection; the init access only captures baselines
  logic [4:0] sens_prev_q;
  logic pres_prev_q;
  logic pf_level_q;
  logic [4:0] ev_set_w;
  wire capture_w = done_w && kind_init_q;
  wire track_w = ready_q && hpc_w;

  assign ev_set_w[hot_plug_pkg::EV_ATTENTION] = track_w && sens_w.attention_button_in &&
                                                !sens_prev_q[0];
  assign ev_set_w[hot_plug_pkg::EV_POWER_FAULT] = track_w && sens_w.power_fault_in &&
                                                  !sens_prev_q[2];
  assign ev_set_w[hot_plug_pkg::EV_LATCH] = track_w &&
                                            (sens_w.retention_latch_in != sens_prev_q[3]);
  assign ev_set_w[hot_plug_pkg::EV_PRESENCE] = track_w && !pd_frozen_w &&
                                               (presence_w != pres_prev_q);
  assign ev_set_w[hot_plug_pkg::EV_COMMAND] = done_w && !kind_init_q;

  wire [4:0] ev_clr_w = (wr_w && sel_sts_w) ? (avs_writedata_i[4:0] & wmask_w[4:0]) : 5'h00;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sens_prev_q <= 5'h00;
      pres_prev_q <= 1'b0;
      evt_q <= 5'h00;
      pf_level_q <= 1'b0;
      retrain_q <= 1'b0;
      link_present_prev_q <= 1'b0;
    end else begin
      link_present_prev_q <= link_present_q;
      if (capture_w || track_w) begin
        sens_prev_q <= sens_w;
      end
      if (capture_w || (track_w && !pd_frozen_w)) begin
        pres_prev_q <= presence_w;
      end
      // Set wins over a write-one clear in the same cycle
      evt_q <= (evt_q & ~ev_clr_w) | ev_set_w;
      pf_level_q <= sens_w.power_fault_in;
      if (hot_reset_i) begin
        retrain_q <= 1'b1;
      end else if (link_present_q && !link_present_prev_q) begin
        retrain_q <= 1'b0;
      end
    end
  end

  // Interlock and power
  logic interlock_level_w;
  interlock_driver #(
    .PULSE_CYCLES(INTERLOCK_CYCLES)
  ) u_interlock (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .fire_i(interlock_fire_w),
    .toggle_mode_i(cfg_q.interlock_toggle_mode),
    .level_o(interlock_level_w)
  );

  // With substitution the latch pin no longer reports a latch
  wire latch_open_w = sens_w.retention_latch_in && !cfg_q.latch_substitution;
  wire auto_off_w = cfg_q.latch_auto_power_off && latch_present_w && latch_open_w;
  wire power_on_w = hpc_w && !ctl_q.slot_power_off_request && !auto_off_w;

  hot_plug_pkg::expander_out_t out_d;
  assign out_d = hot_plug_pkg::expander_out_t'(
    {hpc_w && interlock_level_w, power_on_w, hpc_w && ctl_q.power_indicator,
     hpc_w && ctl_q.attention_indicator} ^ cfg_q.invert[8:5]);

  wire interlock_state_w = cfg_q.latch_substitution ? sens_w.retention_latch_in
                                                    : interlock_level_w;
  wire latch_state_w = cfg_q.latch_substitution ? 1'b0 : sens_w.retention_latch_in;

  // MSI and wakeup pulse when unmasked events first become pending; INTx level while any is pending
  wire [4:0] unmasked_w = evt_q & ctl_q.event_enable;
  wire irq_w = ctl_q.hot_plug_irq_enable && (|unmasked_w);
  wire wake_w = |unmasked_w[3:0];
  logic irq_prev_q;
  logic wake_prev_q;
  logic msi_q;
  logic pme_q;
  logic intx_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_prev_q <= 1'b0;
      wake_prev_q <= 1'b0;
      msi_q <= 1'b0;
      pme_q <= 1'b0;
      intx_q <= 1'b0;
    end else begin
      irq_prev_q <= irq_w;
      wake_prev_q <= wake_w;
      msi_q <= irq_w && !irq_prev_q && pwr_q.msi_enable;
      intx_q <= irq_w && !pwr_q.msi_enable && !pwr_q.legacy_irq_disable;
      pme_q <= wake_w && !wake_prev_q && pwr_q.d3hot;
    end
  end

  // Register writes and read data
  wire [31:0] status_word_w = {23'h000000, interlock_state_w, presence_w, latch_state_w,
                               pf_level_q, evt_q};
  logic [31:0] rdata_d;
  // Merged write words, cut to each register's width
  wire [31:0] cap_m_w = merge({30'h00000000, cap_q}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] ctl_m_w = merge({23'h000000, ctl_q}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] cfg_m_w = merge({19'h00000, cfg_q}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] pwr_m_w = merge({27'h0000000, pwr_q}, avs_writedata_i, avs_byteenable_i);

  always_comb begin
    unique case (avs_address_i)
      hot_plug_pkg::OFS_SLOT_CAPABILITIES: rdata_d = {30'h00000000, cap_q};
      hot_plug_pkg::OFS_SLOT_CONTROL: rdata_d = {23'h000000, ctl_q};
      hot_plug_pkg::OFS_SLOT_STATUS: rdata_d = status_word_w;
      hot_plug_pkg::OFS_HOT_PLUG_CONFIG: rdata_d = {19'h00000, cfg_q};
      hot_plug_pkg::OFS_EXPANDER_ADDRESS: rdata_d = {25'h0000000, addr_q};
      hot_plug_pkg::OFS_POWER_STATE: rdata_d = {27'h0000000, pwr_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      cap_q <= hot_plug_pkg::SLOT_CAPABILITIES_RST;
      ctl_q <= hot_plug_pkg::slot_control_t'(hot_plug_pkg::SLOT_CONTROL_RST);
      cfg_q <= hot_plug_pkg::hot_plug_config_t'(hot_plug_pkg::HOT_PLUG_CONFIG_RST);
      addr_q <= hot_plug_pkg::EXPANDER_ADDRESS_RST;
      pwr_q <= hot_plug_pkg::power_state_t'(hot_plug_pkg::POWER_STATE_RST);
    end else begin
      ack_q <= access_w && !ack_q;
      if (avs_read_i && !ack_q) begin
        rdata_q <= rdata_d;
      end
      if (wr_w && sel_cap_w) begin
        cap_q <= cap_m_w[1:0];
      end
      if (wr_ctl_w) begin
        ctl_q <= ctl_m_w[8:0];
      end
      if (wr_w && sel_cfg_w) begin
        cfg_q <= cfg_m_w[12:0];
      end
      if (wr_adr_w) begin
        addr_q <= avs_writedata_i[6:0];
      end
      if (wr_w && sel_pwr_w) begin
        pwr_q <= pwr_m_w[4:0];
      end
    end
  end

  // Registered pin outputs
  hot_plug_pkg::expander_out_t out_q;
  logic hot_reset_q;
  logic gpio_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      out_q <= hot_plug_pkg::expander_out_t'(4'h0);
      hot_reset_q <= 1'b0;
      gpio_q <= 1'b1;
    end else begin
      out_q <= out_d;
      hot_reset_q <= hot_reset_i;
      gpio_q <= !(pwr_q.gpio_alt_reset && pwr_q.slot_reset);
    end
  end

  assign avs_waitrequest_o = access_w && !ack_q;
  assign avs_readdata_o = rdata_q;
  assign expander_o = out_q;
  assign exp_req_o = (exp_state_q == hot_plug_pkg::EXP_REQ);
  assign exp_init_o = kind_init_q;
  assign exp_addr_o = addr_q;
  assign link_hot_reset_o = hot_reset_q;
  assign msi_req_o = msi_q;
  assign intx_o = intx_q;
  assign pme_req_o = pme_q;
  assign slot_reset_gpio_n_o = gpio_q;

endmodule

// file: rtl/hot_plug_pkg.sv
// Package with register map, field layouts and timing constants for the slot hot-plug controller
package hot_plug_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_SLOT_CAPABILITIES = 5'h00;
  localparam logic [4:0] OFS_SLOT_CONTROL = 5'h04;
  localparam logic [4:0] OFS_SLOT_STATUS = 5'h08;
  localparam logic [4:0] OFS_HOT_PLUG_CONFIG = 5'h0c;
  localparam logic [4:0] OFS_EXPANDER_ADDRESS = 5'h10;
  localparam logic [4:0] OFS_POWER_STATE = 5'h14;

  // Field positions
  localparam int CAP_HOT_PLUG_CAPABLE_BIT = 0;
  localparam int CAP_LATCH_PRESENT_BIT = 1;
  localparam int CTL_INTERLOCK_WRITE_BIT = 9;
  localparam int STS_STATE_LSB = 5;
  localparam int EV_ATTENTION = 0;
  localparam int EV_POWER_FAULT = 1;
  localparam int EV_LATCH = 2;
  localparam int EV_PRESENCE = 3;
  localparam int EV_COMMAND = 4;

  // Reset values
  localparam logic [1:0] SLOT_CAPABILITIES_RST = 2'h0;
  localparam logic [8:0] SLOT_CONTROL_RST = 9'h000;
  localparam logic [12:0] HOT_PLUG_CONFIG_RST = 13'h0000;
  localparam logic [6:0] EXPANDER_ADDRESS_RST = 7'h20;
  localparam logic [4:0] POWER_STATE_RST = 5'h00;

  // Interlock pulse: any length strictly between the bounds, middle taken
  localparam int INTERLOCK_MIN_MS = 100;
  localparam int INTERLOCK_MAX_MS = 150;
  localparam int INTERLOCK_PULSE_MS = (INTERLOCK_MIN_MS + INTERLOCK_MAX_MS) / 2;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int unsigned INTERLOCK_PULSE_CYCLES = INTERLOCK_PULSE_MS * CLK_FREQ_KHZ;

  // Live sensor levels from the expander, raw polarity
  typedef struct packed {
    logic slot_power_good_in;
    logic retention_latch_in;
    logic power_fault_in;
    logic presence_in;
    logic attention_button_in;
  } sensor_in_t;

  // Outputs carried to the expander, pin polarity
  typedef struct packed {
    logic interlock_out;
    logic slot_power_enable_out;
    logic power_indicator_out;
    logic attention_indicator_out;
  } expander_out_t;

  // Invert bits [4:0] follow sensor_in_t, [8:5] follow expander_out_t
  typedef struct packed {
    logic latch_auto_power_off;
    logic latch_substitution;
    logic interlock_toggle_mode;
    logic presence_detect_select;
    logic [8:0] invert;
  } hot_plug_config_t;

  typedef struct packed {
    logic slot_power_off_request;
    logic power_indicator;
    logic attention_indicator;
    logic hot_plug_irq_enable;
    logic [4:0] event_enable;
  } slot_control_t;

  typedef struct packed {
    logic gpio_alt_reset;
    logic slot_reset;
    logic legacy_irq_disable;
    logic msi_enable;
    logic d3hot;
  } power_state_t;

  typedef enum logic [1:0] {
    EXP_IDLE = 2'b00,
    EXP_REQ = 2'b01,
    EXP_DROP = 2'b11
  } exp_state_t;

endpackage

// file: rtl/interlock_driver.sv
// Interlock output driver: timed pulse or toggle on each software command
`timescale 1ns/1ps
module interlock_driver #(
  parameter int unsigned PULSE_CYCLES = hot_plug_pkg::INTERLOCK_PULSE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic fire_i,
  input wire logic toggle_mode_i,
  output logic level_o
);

  localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);

  logic [CW-1:0] count_q;
  logic level_q;

  wire last_w = (count_q == CW'(1));

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      level_q <= 1'b0;
      count_q <= '0;
    end else if (fire_i && toggle_mode_i) begin
      level_q <= ~level_q;
      count_q <= '0;
    end else if (fire_i) begin
      // A new command restarts the pulse
      level_q <= 1'b1;
      count_q <= CW'(PULSE_CYCLES);
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
      if (last_w) begin
        level_q <= 1'b0;
      end
    end
  end

  assign level_o = level_q;

endmodule

// file: bench/slot_hot_plug_sva.sv
// Assertion checker for the slot hot-plug controller ports
`timescale 1ns/1ps
module slot_hot_plug_sva (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic exp_req_o,
  input wire logic exp_init_o,
  input wire logic exp_ack_i,
  input wire logic hot_reset_i,
  input wire logic link_hot_reset_o,
  input wire logic msi_req_o,
  input wire logic pme_req_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_acked;
    exp_req_o && exp_ack_i;
  endsequence
  sequence s_req_on;
    exp_req_o ##1 exp_req_o;
  endsequence
  link_reset_a:
  assert property (hot_reset_i |=> link_hot_reset_o) else $error("link hot reset missing");
  req_hold_a:
  assert property (exp_req_o && !exp_ack_i |=> exp_req_o) else $error("request dropped early");
  req_drop_a:
  assert property (s_acked |-> ##[1:4] !exp_req_o) else $error("request not released");
  req_gap_a:
  assert property ($fell(exp_req_o) |-> !exp_req_o [*2]) else $error("request restarted early");
  init_stable_a:
  assert property (s_req_on |-> $stable(exp_init_o)) else $error("access kind changed");
  bus_idle_a:
  assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o) else $error("idle wait");
  bus_answer_a:
  assert property ((avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
    else $error("bus answer late");
  msi_pulse_a:
  assert property (msi_req_o |=> !msi_req_o) else $error("message request too long");
  pme_pulse_a:
  assert property (pme_req_o |=> !pme_req_o) else $error("wakeup request too long");
endmodule

bind slot_hot_plug slot_hot_plug_sva slot_hot_plug_sva_inst (.ref_clk_i, .srst_i, .avs_read_i,
  .avs_write_i, .avs_waitrequest_o, .exp_req_o, .exp_init_o, .exp_ack_i, .hot_reset_i,
  .link_hot_reset_o, .msi_req_o, .pme_req_o);

// file: bench/expander_model.sv
// Behavioural expander: four-phase handshake and slot sensor pins
`timescale 1ns/1ps
module expander_model (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic exp_req_i,
  input wire logic power_enable_i,
  input wire logic [3:0] delay_i,
  input wire hot_plug_pkg::sensor_in_t want_i,
  output logic exp_ack_o,
  output hot_plug_pkg::sensor_in_t pins_o
);
  logic [3:0] cnt_q;
  logic flt_q;
  logic pen_q;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      exp_ack_o <= 1'b0;
      cnt_q <= 4'h0;
      flt_q <= 1'b0;
      pen_q <= 1'b0;
    end else begin
      pen_q <= power_enable_i;
      if (!exp_req_i) begin
        exp_ack_o <= 1'b0;
        cnt_q <= 4'h0;
      end else if (!exp_ack_o) begin
        if (cnt_q >= delay_i) exp_ack_o <= 1'b1;
        else cnt_q <= cnt_q + 4'h1;
      end
      // Fault sticks until power enable moves
      if (want_i.power_fault_in) flt_q <= 1'b1;
      else if (pen_q != power_enable_i) flt_q <= 1'b0;
    end
  end
  always_comb begin
    pins_o = want_i;
    pins_o.power_fault_in = want_i.power_fault_in | flt_q;
  end
endmodule

// file: bench/slot_hot_plug_tb.sv
// Self-checking bench for the slot hot-plug controller
`timescale 1ns/1ps
module slot_hot_plug_tb;
  localparam int IL = 20;
  logic clk = 0, srst = 1, rd = 0, wr = 0, eed = 0, hrst = 0, lclk = 0, lup = 0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, q;
  logic [31:0] mir [32];
  logic [3:0] dly = 4'h0;
  hot_plug_pkg::sensor_in_t want = 5'h02;
  hot_plug_pkg::sensor_in_t pins;
  hot_plug_pkg::expander_out_t xo;
  logic [31:0] rdat;
  logic wreq, ack, xreq, xinit, msi, intx, pme, lhr, gpn;
  logic [6:0] xadr;
  int fails = 0, total_checks = 0, cyc = 0, n, k, m, p;
  slot_hot_plug #(.INTERLOCK_CYCLES(IL)) slot_hot_plug_inst (.ref_clk_i(clk), .srst_i(srst),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .slot_sensors_i(pins), .expander_o(xo), .exp_req_o(xreq), .exp_init_o(xinit),
    .exp_addr_o(xadr), .exp_ack_i(ack), .eeprom_done_i(eed), .hot_reset_i(hrst),
    .link_clk_i(lclk), .link_up_i(lup), .link_hot_reset_o(lhr), .msi_req_o(msi),
    .intx_o(intx), .pme_req_o(pme), .slot_reset_gpio_n_o(gpn));
  expander_model expander_model_inst (.ref_clk_i(clk), .srst_i(srst), .exp_req_i(xreq),
    .power_enable_i(xo.slot_power_enable_out), .delay_i(dly), .want_i(want),
    .exp_ack_o(ack), .pins_o(pins));
  initial forever #2.5 clk = ~clk;
  // Link clock free running, phase unrelated to the core clock
  initial begin
    #3.3;
    forever #32 lclk = ~lclk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      wrap_up;
    end
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    if (w) mir[a] = d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task idle;
    for (n = 0; n < 200 && (xreq !== 1'b0 || ack !== 1'b0); n++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task wreq_up;
    for (n = 0; n < 200 && xreq !== 1'b1; n++) @(posedge clk);
  endtask
  // Flip one sensor and count message and wakeup pulses
  task ev(input int b);
    @(posedge clk) want[b] <= ~want[b];
    m = 0;
    p = 0;
    repeat (30) begin
      @(posedge clk);
      m += (msi === 1'b1);
      p += (pme === 1'b1);
    end
  endtask
  initial begin
    n = $urandom(32'h8161);
    dly = 4'($urandom_range(7));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rchk(5'h00, 32'h0);
    rchk(5'h04, 32'h0);
    rchk(5'h0c, 32'h0);
    rchk(5'h10, 32'h20);
    bus(1'b1, 5'h18, 32'hffffffff);
    rchk(5'h18, 32'h0);
    bus(1'b1, 5'h00, 32'h3);
    repeat (30) @(posedge clk);
    chk(xreq, 1'b0);
    @(posedge clk) eed <= 1'b1;
    wreq_up;
    chk(xinit, 1'b1);
    chk(xadr, 7'h20);
    idle;
    bus(1'b0, 5'h08, 32'h0);
    chk(q[4:0], 5'h00);
    chk(q[7], 1'b1);
    k = $urandom_range(127);
    bus(1'b1, 5'h10, k);
    wreq_up;
    chk(xadr, k[6:0]);
    idle;
    rchk(5'h10, mir[5'h10]);
    // Invert presence input and attention indicator output
    bus(1'b1, 5'h0c, 32'h22);
    idle;
    bus(1'b0, 5'h08, 32'h0);
    chk(q[7], 1'b0);
    chk(xo.attention_indicator_out, 1'b1);
    bus(1'b1, 5'h0c, 32'h0);
    idle;
    bus(1'b1, 5'h08, 32'h1f);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[3], 1'b0);
    bus(1'b1, 5'h14, 32'h2);
    bus(1'b1, 5'h04, 32'h28);
    idle;
    bus(1'b1, 5'h08, 32'h1f);
    ev(1);
    chk(m, 1);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[3], 1'b1);
    bus(1'b1, 5'h08, 32'h8);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[3], 1'b0);
    bus(1'b1, 5'h14, 32'h0);
    ev(1);
    chk(m, 0);
    chk(intx, 1'b1);
    bus(1'b1, 5'h08, 32'h8);
    repeat (3) @(posedge clk);
    chk(intx, 1'b0);
    // Wakeup table: control word, expected wakeups, expected legacy level
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 5'h04, i == 0 ? 32'h08 : (i == 1 ? 32'h28 : 32'h20));
      idle;
      bus(1'b1, 5'h14, 32'h1);
      bus(1'b1, 5'h08, 32'h1f);
      ev(1);
      chk(p, i < 2);
      chk(intx, i == 1);
      chk(m, 0);
      bus(1'b1, 5'h08, 32'h1f);
    end
    bus(1'b1, 5'h04, 32'h10);
    k = 0;
    repeat (40) begin
      @(posedge clk);
      k += (pme === 1'b1);
    end
    chk(k, 0);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[4], 1'b1);
    rchk(5'h14, 32'h1);
    bus(1'b1, 5'h14, 32'h0);
    bus(1'b1, 5'h04, 32'h0);
    idle;
    bus(1'b1, 5'h04, 32'h200);
    k = 0;
    repeat (60) begin
      @(posedge clk);
      k += (xo.interlock_out === 1'b1);
    end
    chk(k, IL);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[8], 1'b0);
    bus(1'b1, 5'h0c, 32'h400);
    bus(1'b1, 5'h04, 32'h200);
    repeat (60) @(posedge clk);
    chk(xo.interlock_out, 1'b1);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[8], 1'b1);
    bus(1'b1, 5'h04, 32'h200);
    repeat (5) @(posedge clk);
    chk(xo.interlock_out, 1'b0);
    // Latch stands in for interlock state
    bus(1'b1, 5'h0c, 32'h800);
    @(posedge clk) want.retention_latch_in <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[8], 1'b1);
    chk(q[6], 1'b0);
    @(posedge clk) want.retention_latch_in <= 1'b0;
    bus(1'b1, 5'h0c, 32'h1000);
    idle;
    chk(xo.slot_power_enable_out, 1'b1);
    @(posedge clk) want.retention_latch_in <= 1'b1;
    repeat (10) @(posedge clk);
    chk(xo.slot_power_enable_out, 1'b0);
    @(posedge clk) want.retention_latch_in <= 1'b0;
    bus(1'b1, 5'h0c, 32'h0);
    idle;
    @(posedge clk) want.power_fault_in <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[5], 1'b1);
    chk(q[1], 1'b1);
    @(posedge clk) want.power_fault_in <= 1'b0;
    bus(1'b1, 5'h04, 32'h100);
    idle;
    bus(1'b1, 5'h04, 32'h0);
    idle;
    bus(1'b0, 5'h08, 32'h0);
    chk(q[5], 1'b0);
    // In-band presence, then retraining after hot reset
    bus(1'b1, 5'h0c, 32'h200);
    bus(1'b1, 5'h08, 32'h1f);
    @(posedge clk) lup <= 1'b1;
    repeat (60) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[7], 1'b1);
    chk(q[3], 1'b1);
    bus(1'b1, 5'h08, 32'h1f);
    @(posedge clk) hrst <= 1'b1;
    @(posedge clk) hrst <= 1'b0;
    lup <= 1'b0;
    repeat (60) @(posedge clk);
    lup <= 1'b1;
    repeat (60) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0);
    chk(q[3], 1'b0);
    bus(1'b1, 5'h14, 32'h08);
    repeat (3) @(posedge clk);
    chk(gpn, 1'b1);
    bus(1'b1, 5'h14, 32'h18);
    repeat (3) @(posedge clk);
    chk(gpn, 1'b0);
    wrap_up;
  end
endmodule
